// ---- pkg/audio_source_pkg.sv ----
// What this block does
// - Device in secondary role needs both bit clock and frame sync driven by us.
// - Words go out most significant bit first as signed two's complement.
// - Each sample occupies its own slot inside the frame.
// - Samples spread over four data lines carrying different channels together; TDM uses the first line only.
// - I2S: MSB valid on second capture edge after any frame sync transition.
// - Left-justified: MSB valid on first capture edge after any frame sync transition.
// - I2S and left-justified: later bits follow on each next bit clock cycle.
// - TDM: first channel MSB valid on second capture edge after rising sync.
// - TDM: each later slot starts right after the previous slot's last bit.
// - Secondary TDM: sync pulse under one frame, falls a bit clock before next; the block drives a one-bit pulse instead.
// - 8-slot TDM: channels one to eight sit in slots zero to seven.
// - Bit clock is a constant integer multiple of the sample rate.
package audio_source_pkg;

  localparam int unsigned CORE_PERIOD_NS = 10;
  localparam int unsigned BCLK_PERIOD_NS = 160;
  localparam logic [7:0]  HALF_DIV_RESET =
    8'(BCLK_PERIOD_NS / (2 * CORE_PERIOD_NS));
  localparam logic [9:0]  FRAME_LEN_RESET = 10'h040;

  // Register offsets
  localparam logic [7:0] CTRL_ADDR    = 8'h00;
  localparam logic [7:0] CLKCFG_ADDR  = 8'h04;
  localparam logic [7:0] STATUS_ADDR  = 8'h08;
  localparam logic [2:0] SAMPLE_PAGE  = 3'h1;  // 0x20..0x3c, one per channel

  // Field positions
  localparam int unsigned HALF_LSB  = 0;
  localparam int unsigned FRAME_LSB = 16;
  localparam int unsigned FCNT_LSB  = 0;
  localparam int unsigned FSLV_BIT  = 16;

  localparam int unsigned WORD_BITS  = 32;
  localparam int unsigned CHANNELS   = 8;
  localparam int unsigned DATA_LINES = 4;
  localparam logic [10:0] TDM_END    = 11'h100;  // eight slots of 32 bits

  typedef enum logic [1:0] {
    FMT_I2S  = 2'h0,
    FMT_LEFT = 2'h1,
    FMT_TDM  = 2'h3
  } format_type;

  typedef struct packed {
    logic [1:0] straps;
    logic       invert;
    format_type fmt;
    logic       host_clk;
    logic       run;
  } ctrl_type;

  localparam ctrl_type CTRL_RESET = 7'h00;

  typedef struct packed {
    logic       bclk_o;
    logic       bclk_oe;
    logic       frame_sync_o;
    logic       frame_sync_oe;
    logic [3:0] data_o;
  } link_out_type;

endpackage : audio_source_pkg

// ---- verilog/audio_source_ctrl.sv ----
// Strobed register access and the register offsets were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module audio_source_ctrl
  import audio_source_pkg::*;
#(
  parameter int unsigned NUM_CH = CHANNELS
)(
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         reset_n,
  // Register port
  input  wire logic [7:0]   addr,
  input  wire logic [31:0]  wdata,
  input  wire logic         wr_en,
  input  wire logic         rd_en,
  output logic [31:0]       rdata,
  // Link pins
  input  wire logic         bclk_i,
  input  wire logic         frame_sync_i,
  output link_out_type      link_o,
  output logic [1:0]        config_strap_pins
);

  ctrl_type               ctrl_q;
  logic [7:0]             half_q;
  logic [9:0]             flen_q;
  logic [WORD_BITS-1:0]   smp_q  [NUM_CH];
  logic [WORD_BITS-1:0]   shd_q  [NUM_CH];
  logic [31:0]            rdata_q;
  logic [1:0]             s1_q, s2_q, s3_q, filt_q;
  logic                   bclk_prev_q;
  logic [7:0]             div_q;
  logic                   bclk_q;
  logic [9:0]             fpos_q;
  logic                   fs_q, fs_last_q;
  logic [10:0]            pos_q;
  logic [3:0]             data_q;
  logic [15:0]            fcnt_q;

  ////////////////////////////////////////////////////////////////////
  // Register decode
  wire       wr_ctrl = wr_en && (addr == CTRL_ADDR);
  wire       wr_clk  = wr_en && (addr == CLKCFG_ADDR);
  wire       wr_smp  = wr_en && (addr[7:5] == SAMPLE_PAGE);
  wire [2:0] smp_idx = addr[4:2];
  wire       is_tdm  = (ctrl_q.fmt == FMT_TDM);
  wire       is_lj   = (ctrl_q.fmt == FMT_LEFT);
  wire       run     = ctrl_q.run;
  wire       host_run = run && ctrl_q.host_clk;

  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = 32'h0000_0000;  // Unmapped reads return zero
    if (addr == CTRL_ADDR)
      rd_mux = {25'h0, ctrl_q};
    else if (addr == CLKCFG_ADDR)
      rd_mux = {6'h0, flen_q, 8'h00, half_q};
    else if (addr == STATUS_ADDR)
      rd_mux = {15'h0, fs_last_q, fcnt_q};
    else if (addr[7:5] == SAMPLE_PAGE && 32'(smp_idx) < NUM_CH)
      rd_mux = smp_q[smp_idx];
  end

  // Control registers
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ctrl_q  <= CTRL_RESET;
      half_q  <= HALF_DIV_RESET;
      flen_q  <= FRAME_LEN_RESET;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_q <= ctrl_type'(wdata[6:0]);
      if (wr_clk)
      begin
        half_q <= wdata[HALF_LSB +: 8];
        flen_q <= wdata[FRAME_LSB +: 10];
      end
      rdata_q <= rd_en ? rd_mux : 32'h0000_0000;
    end
  end

  assign rdata = rdata_q;
  // strap bit 0 picks device role; format comes from the field
  assign config_strap_pins = ctrl_q.straps;

  ////////////////////////////////////////////////////////////////////
  // Pin synchronisers: bit 0 bit clock, bit 1 frame sync.
  // A change counts only once stages two and three agree, which rejects
  // a single-sample glitch on a slow pin edge.
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s1_q        <= 2'h0;
      s2_q        <= 2'h0;
      s3_q        <= 2'h0;
      filt_q      <= 2'h0;
      bclk_prev_q <= 1'b0;
    end
    else
    begin
      s1_q        <= {frame_sync_i, bclk_i};
      s2_q        <= s1_q;
      s3_q        <= s2_q;
      filt_q      <= (s2_q & ~(s2_q ^ s3_q)) | (filt_q & (s2_q ^ s3_q));
      bclk_prev_q <= filt_q[0];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Bit clock divider, only when we own the clocks
  wire [7:0] half_m1 = (half_q == 8'h00) ? 8'h00 : half_q - 8'h01;
  wire       tick    = host_run && (div_q >= half_m1);

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      div_q  <= 8'h00;
      bclk_q <= 1'b0;
    end
    else if (!host_run)
    begin
      div_q  <= 8'h00;
      bclk_q <= 1'b0;
    end
    else if (tick)
    begin
      div_q  <= 8'h00;
      bclk_q <= ~bclk_q;
    end
    else
      div_q <= div_q + 8'h01;
  end

  // edges of the device's clock come from the synchroniser
  wire rise = ctrl_q.host_clk ? (tick && !bclk_q) : (filt_q[0] && !bclk_prev_q);
  wire fall = ctrl_q.host_clk ? (tick && bclk_q) : (!filt_q[0] && bclk_prev_q);
  wire launch = run && (ctrl_q.invert ? rise : fall);

  ////////////////////////////////////////////////////////////////////
  // Frame sync generation
  wire [9:0] fpos_inc  = fpos_q + 10'h001;
  wire [9:0] fpos_next = (fpos_inc >= flen_q) ? 10'h000 : fpos_inc;
  wire [9:0] half_len  = {1'b0, flen_q[9:1]};
  logic      fs_gen;
  always_comb
  begin
    // TDM: one bit clock pulse per frame; I2S and left-justified hold a half-frame level
    // pulse ends long before the next frame
    if (is_tdm)
      fs_gen = (fpos_next == 10'h000);
    else
      fs_gen = (fpos_next >= half_len) ^ is_lj;
  end

  // frame length is a fixed count of bit clocks
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      fpos_q <= 10'h000;
      fs_q   <= 1'b0;
    end
    else if (!host_run)
    begin
      fpos_q <= 10'h000 - 10'h001;  // First launch lands on position zero
      fs_q   <= 1'b0;
    end
    else if (launch)
    begin
      fpos_q <= fpos_next;
      fs_q   <= fs_gen;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Bit position tracking, common to both clock owners
  wire fs_new = ctrl_q.host_clk ? fs_gen : filt_q[1];
  // TDM frames restart on the rising sync only
  wire trans  = is_tdm ? (fs_new && !fs_last_q) : (fs_new != fs_last_q);
  wire fstart = trans && (is_tdm || (fs_new == is_lj));
  wire [10:0] nidx = trans ? 11'h000 :
                     (pos_q == 11'h7ff) ? pos_q : pos_q + 11'h001;
  // one cycle delay for I2S and TDM
  wire        dly   = !is_lj;
  wire        valid = (nidx >= {10'h000, dly});
  wire [10:0] bidx  = nidx - {10'h000, dly};
  // one bit per cycle, idle after the word
  wire        in_word = valid && (bidx < 11'(WORD_BITS));
  // slots back to back, idle after slot seven
  wire        in_tdm  = valid && (bidx < TDM_END);
  wire [4:0]  bsel  = 5'h1f - bidx[4:0];
  wire        right = fs_new ^ is_lj;

  // New frame reads the live samples, later bits the frozen copy
  logic [WORD_BITS-1:0] cur_w [NUM_CH];
  logic [3:0]           bit_d;

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++)
    begin : g_ch
      assign cur_w[g] = fstart ? smp_q[g] : shd_q[g];
      // Sample and shadow words; frozen at frame start for coherence
      always_ff @(posedge core_clk or negedge reset_n)
      begin
        if (!reset_n)
        begin
          smp_q[g] <= '0;
          shd_q[g] <= '0;
        end
        else
        begin
          if (wr_smp && 32'(smp_idx) == g)
            smp_q[g] <= wdata;
          if (launch && fstart)
            shd_q[g] <= smp_q[g];
        end
      end
    end
    for (g = 0; g < DATA_LINES; g++)
    begin : g_line
      // line g carries channels 2g and 2g+1
      wire [2:0] ch_lr  = {2'(g), right};
      wire [2:0] ch_tdm = bidx[7:5];
      if (g == 0)
      begin : g_first
        assign bit_d[g] = is_tdm ? (in_tdm && cur_w[ch_tdm][bsel])
                                 : (in_word && cur_w[ch_lr][bsel]);
      end
      else
      begin : g_rest
        // TDM uses the first line only
        assign bit_d[g] = !is_tdm && in_word && cur_w[ch_lr][bsel];
      end
    end
  endgenerate

  // Data launch and frame counting
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pos_q     <= 11'h7ff;
      fs_last_q <= 1'b0;
      data_q    <= 4'h0;
      fcnt_q    <= 16'h0000;
    end
    else if (!run)
    begin
      pos_q     <= 11'h7ff;  // Stay idle until the first sync
      fs_last_q <= fs_new;
      data_q    <= 4'h0;
    end
    else if (launch)
    begin
      pos_q     <= nidx;
      fs_last_q <= fs_new;
      data_q    <= bit_d;
      if (fstart)
        fcnt_q <= fcnt_q + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Pin drive
  assign link_o.bclk_o   = bclk_q;
  assign link_o.bclk_oe  = host_run;
  assign link_o.frame_sync_o  = fs_q;
  assign link_o.frame_sync_oe = host_run;
  assign link_o.data_o   = data_q;

endmodule : audio_source_ctrl
`default_nettype wire

// ---- verification/audio_source_ctrl_assertions.sv ----
`timescale 1ns/1ns
`default_nettype none
module audio_source_ctrl_assertions
  import audio_source_pkg::*;
#(parameter int unsigned NUM_CH = CHANNELS)
(
  // Clock and register port
  input wire logic         core_clk,
  input wire logic         reset_n,
  input wire logic [7:0]   addr,
  input wire logic [31:0]  wdata,
  input wire logic         wr_en,
  input wire logic         rd_en,
  input wire logic [31:0]  rdata,
  // Link pins
  input wire logic         bclk_i,
  input wire logic         frame_sync_i,
  input wire link_out_type link_o,
  input wire logic [1:0]   config_strap_pins
);
  ctrl_type   ctrl_q;
  logic [1:0] tgl_q;
  wire logic  wr_ctrl = wr_en && addr == CTRL_ADDR;
  wire logic  tdm_out = link_o.frame_sync_oe && ctrl_q.fmt == FMT_TDM;

  // Shadow of the control word, so checks know the mode
  always_ff @(posedge core_clk or negedge reset_n)
    if (!reset_n) ctrl_q <= CTRL_RESET;
    else if (wr_ctrl) ctrl_q <= ctrl_type'(wdata[6:0]);

  // Bit clock toggles while sync is high; saturates so a stuck sync shows
  always_ff @(posedge core_clk or negedge reset_n)
    if (!reset_n) tgl_q <= 2'h0;
    else if (!link_o.frame_sync_o) tgl_q <= 2'h0;
    else if ($changed(link_o.bclk_o) && tgl_q != 2'h3) tgl_q <= tgl_q + 2'h1;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  a_rdata_quiet: assert property (!$past(rd_en) |-> rdata == 32'h0)
    else $error("read data outside its cycle");
  a_ctrl_readback: assert property ($past(rd_en && addr == CTRL_ADDR) |-> rdata == 32'(ctrl_q))
    else $error("control readback wrong");
  a_oe_follows: assert property (link_o.bclk_oe == (ctrl_q.run && ctrl_q.host_clk))
    else $error("clock enable wrong");
  a_oe_pair: assert property (link_o.frame_sync_oe == link_o.bclk_oe)
    else $error("enables differ");
  a_straps_track: assert property (config_strap_pins == ctrl_q.straps)
    else $error("straps wrong");
  a_stop_quiet: assert property (!ctrl_q.run && !$past(ctrl_q.run) |-> link_o.data_o == 4'h0)
    else $error("data while stopped");
  a_tdm_one_line: assert property (ctrl_q.fmt == FMT_TDM && $past(ctrl_q) == ctrl_q |-> link_o.data_o[3:1] == 3'h0)
    else $error("extra lines busy in TDM");
  // Data and sync move on the launch edge, so only the capture edge must find them still
  a_data_settled: assert property (link_o.bclk_oe && $changed(link_o.bclk_o) && link_o.bclk_o != ctrl_q.invert |-> $stable(link_o.data_o))
    else $error("data moved on capture edge");
  a_sync_settled: assert property (link_o.frame_sync_oe && $changed(link_o.bclk_o) && link_o.bclk_o != ctrl_q.invert |-> $stable(link_o.frame_sync_o))
    else $error("sync moved on capture edge");
  a_tdm_pulse: assert property (tdm_out && $fell(link_o.frame_sync_o) |-> tgl_q == 2'h2)
    else $error("sync pulse not one bit");
endmodule : audio_source_ctrl_assertions

bind audio_source_ctrl audio_source_ctrl_assertions #(.NUM_CH(NUM_CH)) u_audio_source_ctrl_assertions (
  .core_clk(core_clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
  .rd_en(rd_en), .rdata(rdata), .bclk_i(bclk_i), .frame_sync_i(frame_sync_i), .link_o(link_o),
  .config_strap_pins(config_strap_pins));
`default_nettype wire

// ---- verification/audio_source_device_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module audio_source_device_model
  import audio_source_pkg::*;
(
  // Controller pins and format field
  input  wire link_out_type link_o,
  input  wire logic [1:0]   config_strap_pins,
  input  wire format_type   fmt,
  // Resolved wires and captured words
  output logic              bclk_w,
  output logic              fs_w,
  output logic [31:0]       got [CHANNELS],
  output int                frames
);
  logic        dev_bclk = 1'b0;
  logic        dev_fs = 1'b0;
  logic        fs_p = 1'b0;
  logic [31:0] sh [DATA_LINES];
  int          fpos = 0;
  int          pos = 0;
  int          idx;
  // Role from first strap, format from field
  wire logic   primary = config_strap_pins[0];
  wire logic   tdm = fmt == FMT_TDM;
  wire logic   lj = fmt == FMT_LEFT;

  initial frames = 0;
  // Whoever enables a pin drives the wire
  assign bclk_w = link_o.bclk_oe ? link_o.bclk_o : dev_bclk;
  assign fs_w = link_o.frame_sync_oe ? link_o.frame_sync_o : dev_fs;

  // Fixed clock period; 80-bit frames leave idle bits
  // TDM frames of 264 bits, sync pulse one bit wide
  // Own sync pulse falls long before the next frame starts
  // Eight channels at full rate, one-bit input never enabled
  always #80
  begin
    dev_bclk = primary && !dev_bclk;
    if (primary && !dev_bclk)
    begin
      fpos = (fpos + 1) % (tdm ? 264 : 80);
      dev_fs = tdm ? fpos == 0 : (fpos >= 40) ^ lj;
    end
  end

  always @(posedge bclk_w)
  begin
    pos = (tdm ? fs_w && !fs_p : fs_w != fs_p) ? 0 : pos + 1;
    fs_p = fs_w;
    idx = pos - (lj ? 0 : 1);
    if (idx >= 0 && idx < (tdm ? 256 : 32))
    begin
      for (int g = 0; g < DATA_LINES; g++)
        sh[g] = {sh[g][30:0], link_o.data_o[g]};
      if (idx % 32 == 31)
      begin
        if (tdm)
          got[idx / 32] = sh[0];
        else
          for (int g = 0; g < DATA_LINES; g++)
            got[2 * g + int'(fs_w ^ lj)] = sh[g];
        if (tdm ? idx == 255 : fs_w ^ lj)
          frames++;
      end
    end
  end
endmodule : audio_source_device_model
`default_nettype wire

// ---- verification/tb_audio_source_ctrl.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb_audio_source_ctrl
  import audio_source_pkg::*;
;
  logic         core_clk = 1'b0;
  logic         reset_n = 1'b0;
  logic [7:0]   addr = 8'h00;
  logic [31:0]  wdata = 32'h0;
  logic         wr_en = 1'b0;
  logic         rd_en = 1'b0;
  logic [31:0]  rdata;
  logic         bclk_w;
  logic         fs_w;
  link_out_type link_o;
  logic [1:0]   config_strap_pins;
  format_type   dev_fmt = FMT_I2S;
  format_type   fmts [3] = '{FMT_I2S, FMT_LEFT, FMT_TDM};
  logic [31:0]  got [CHANNELS];
  int           frames;
  int           fails = 0;
  int           total_checks = 0;

  always #5 core_clk = ~core_clk;

  audio_source_ctrl u_audio_source_ctrl (.core_clk(core_clk), .reset_n(reset_n),
    .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
    .bclk_i(bclk_w), .frame_sync_i(fs_w), .link_o(link_o), .config_strap_pins(config_strap_pins));
  audio_source_device_model u_audio_source_device_model (.link_o(link_o),
    .config_strap_pins(config_strap_pins), .fmt(dev_fmt), .bclk_w(bclk_w), .fs_w(fs_w),
    .got(got), .frames(frames));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge core_clk);
    wr_en <= 1'b0;
  endtask : wr

  // Read data only stand in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge core_clk);
    rd_en <= 1'b0;
    @(negedge core_clk);
    check(rdata, exp);
  endtask : rd

  function automatic logic [31:0] smp(input int r, input int n);
    return {1'b1, 3'(r), 4'(n), 24'h5a3c81};
  endfunction : smp

  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : summarize

  // Stop, load fresh samples, set framing, start, then compare captured words
  task automatic run_pass(input int r, input format_type f, input logic dev_pri);
    int w;
    wr(CTRL_ADDR, 32'h0);
    for (int n = 0; n < CHANNELS; n++)
      wr({SAMPLE_PAGE, 3'(n), 2'b00}, smp(r, n));
    rd({SAMPLE_PAGE, 3'h7, 2'b00}, smp(r, 7));
    wr(CLKCFG_ADDR, {6'h0, (f == FMT_TDM) ? 10'h108 : 10'h050, 16'h0008});
    dev_fmt <= f;
    wr(CTRL_ADDR, 32'({1'b0, dev_pri, 1'b0, f, !dev_pri, 1'b1}));
    rd(CTRL_ADDR, 32'({1'b0, dev_pri, 1'b0, f, !dev_pri, 1'b1}));
    w = frames;
    for (int k = 0; k < 20000 && frames < w + 3; k++)
      @(posedge core_clk);
    check(32'(frames - w >= 3), 32'h1);
    for (int n = 0; n < CHANNELS; n++)
      check(got[n], smp(r, n));
  endtask : run_pass

  ////////////////////////////////////////////////////////////////////////////
  // Reset values, unmapped place, then every format in both clock roles
  initial
  begin
    repeat (3) @(posedge core_clk);
    reset_n <= 1'b1;
    rd(CTRL_ADDR, 32'h0);
    rd(CLKCFG_ADDR, {6'h0, FRAME_LEN_RESET, 8'h00, HALF_DIV_RESET});
    rd(STATUS_ADDR, 32'h0);
    wr(8'h10, 32'hffff_ffff);
    rd(8'h10, 32'h0);
    for (int p = 0; p < 6; p++)
      run_pass(p, fmts[p % 3], p >= 3);
    summarize();
  end

  // Six passes of at most four frames need about 55000 cycles; margin kept under 100000
  initial
  begin
    repeat (90000) @(posedge core_clk);
    fails++;
    summarize();
  end
endmodule : tb_audio_source_ctrl
`default_nettype wire
